// ==== core/tmc_timer.sv ====
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Each timer tick steps the count by one up or down, or clears it.
// - Clock select zero produces no tick; the count holds.
// - Software reads and writes the count at any time.
// - A software count write beats the count step and match of any tick in the same cycle.
// - Waveform mode bits choose direction and clear point of the sequence.
// - Overflow flag sets at the mode-dependent point, never in fast PWM, and can raise an interrupt.
// - An 8-bit comparator flags equality of count and active compare every cycle.
// - A match sets the compare match flag one timer tick later.
// - Enabled set match flag requests an interrupt; servicing clears it.
// - Writing one to the match flag clears it; zero leaves it.
// - Match, top and bottom indications go out to the waveform logic.
// - Compare is double buffered in PWM modes, direct in normal and clear-on-match.
// - Buffered compare copies to active only at top or bottom.
// - Compare address reaches the buffer when buffered, else the active register.
// - Force strobe in non-PWM modes updates output only, no flag, no clear.
// - A count write blocks the match flag and output action during the next timer tick.
// - The output state survives a waveform mode change.
// - Output mode bits bypass the compare buffer and act at once.
// - Bottom shows when count is zero, top when count reaches sequence top.
// - Maximum count is 0xFF; top is maximum or compare, by mode.
// - Bottom is the count value 0x00.
module tmc_timer
    import tmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    input  wire logic        overflowIrqAck,
    input  wire logic        compareIrqAck,
    output      logic        overflowIrq,
    output      logic        compareIrq,
    output      logic        matchOut,
    output      logic        topOut,
    output      logic        bottomOut,
    output      logic        countDownOut,
    output      logic [1:0]  compareOutputMode,
    output      logic        compareOutputState
);
    import tmc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic                  awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [7:0]            awAddr_q;
    logic [31:0]           wData_q, rdata_q;
    logic [3:0]            wStrb_q;
    logic [1:0]            bresp_q, rresp_q;
    logic [2:0]            clockSelect_q;
    tmc_wave_mode_t        waveMode_q;
    logic [1:0]            outMode_q;
    logic [7:0]            count_q, compareActive_q, compareBuffer_q;
    logic                  overflowFlag_q, matchFlag_q, outState_q, countDown_q, blockMatch_q;
    logic [1:0]            irqEnable_q;
    logic [PRESCALE_W-1:0] prescale_q;
    logic                  doWrite, wrLane0, tick, isPwm, match, atTop, atBottom;
    logic                  cpuCountWr, cpuCtrlWr, cpuCompareWr, cpuStatusWr, forceStrobe;
    logic                  matchEvent, reloadPoint, nextDown, pwmLevel, wrapPoint;
    logic [7:0]            topValue, countNext;

    // Tick mask per clock select: each nonzero setting picks a power-of-two division.
    function automatic logic [PRESCALE_W-1:0] tick_mask(input logic [2:0] sel);
        unique case (sel)
            3'h0, 3'h1: tick_mask = 10'h000;
            3'h2:       tick_mask = 10'h007;
            3'h3:       tick_mask = 10'h01F;
            3'h4:       tick_mask = 10'h03F;
            3'h5:       tick_mask = 10'h07F;
            3'h6:       tick_mask = 10'h0FF;
            3'h7:       tick_mask = 10'h3FF;
        endcase
    endfunction

    // Non-PWM output action: toggle, clear or set by the output mode bits.
    function automatic logic non_pwm_action(input logic [1:0] om, input logic cur);
        unique case (om)
            2'h0: non_pwm_action = cur;
            2'h1: non_pwm_action = ~cur;
            2'h2: non_pwm_action = 1'b0;
            2'h3: non_pwm_action = 1'b1;
        endcase
    endfunction

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // Address and data are taken independently; the write fires once both are held.
    assign awready = ~awHeld_q;
    assign wready  = ~wHeld_q;
    assign arready = ~rvalid_q;
    assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;
    assign wrLane0 = doWrite & wStrb_q[0];
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;

    // Write address and data holding stages.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            else if (doWrite)
            begin
                awHeld_q <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            else if (doWrite)
            begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // Write response; an unmapped or read-only offset answers SLVERR.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid_q <= 1'b1;
            unique case (awAddr_q)
                OFS_CTRL, OFS_COUNT, OFS_COMPARE, OFS_STATUS, OFS_IRQEN: bresp_q <= RESP_OKAY;
                default: bresp_q <= RESP_SLVERR;
            endcase
        end
        else if (bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel, answered the cycle after the address is taken.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else if (arvalid && arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            unique case (araddr)
                OFS_CTRL:    rdata_q <= {24'h000000, 1'b0, outMode_q, waveMode_q, clockSelect_q};
                OFS_COUNT:   rdata_q <= {24'h000000, count_q};
                OFS_COMPARE: rdata_q <= {24'h000000, isPwm ? compareBuffer_q : compareActive_q};
                OFS_STATUS:  rdata_q <= {30'h00000000, matchFlag_q, overflowFlag_q};
                OFS_IRQEN:   rdata_q <= {30'h00000000, irqEnable_q};
                OFS_STATE:   rdata_q <= {23'h000000, outState_q, compareActive_q};
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else if (rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    assign cpuCtrlWr    = wrLane0 && (awAddr_q == OFS_CTRL);
    assign cpuCountWr   = wrLane0 && (awAddr_q == OFS_COUNT);
    assign cpuCompareWr = wrLane0 && (awAddr_q == OFS_COMPARE);
    assign cpuStatusWr  = wrLane0 && (awAddr_q == OFS_STATUS);
    // The force bit is a strobe and never stored, so it always reads zero.
    assign forceStrobe  = cpuCtrlWr && wData_q[CTRL_FORCE_BIT];

    // Control and interrupt enable registers.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clockSelect_q <= 3'h0;
            waveMode_q    <= WM_NORMAL;
            outMode_q     <= 2'h0;
            irqEnable_q   <= 2'h0;
        end
        else
        begin
            if (cpuCtrlWr)
            begin
                clockSelect_q <= wData_q[CTRL_CS_LSB +: 3];
                waveMode_q    <= tmc_wave_mode_t'(wData_q[CTRL_WM_LSB +: 2]);
                outMode_q     <= wData_q[CTRL_OM_LSB +: 2];
            end
            if (wrLane0 && (awAddr_q == OFS_IRQEN))
            begin
                irqEnable_q <= wData_q[1:0];
            end
        end
    end

    // ****************************************************************
    // Tick and counter
    // ****************************************************************
    // Free-running prescaler; a tick fires when the selected low bits are all ones.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prescale_q <= 10'h000;
        end
        else
        begin
            prescale_q <= prescale_q + 10'h001;
        end
    end

    assign tick = (clockSelect_q != 3'h0) &&
                  ((prescale_q & tick_mask(clockSelect_q)) == tick_mask(clockSelect_q));

    assign isPwm    = (waveMode_q == WM_PHASE_PWM) || (waveMode_q == WM_FAST_PWM);
    assign topValue = (waveMode_q == WM_CLEAR_ON_MATCH) ? compareActive_q : COUNT_MAX;
    assign atTop    = (count_q == topValue);
    assign atBottom = (count_q == COUNT_BOTTOM);
    assign match    = (count_q == compareActive_q);
    // Point where a normal or clear-on-match sequence leaves the maximum and wraps to bottom.
    assign wrapPoint = tick && (count_q == COUNT_MAX) && !isPwm;
    // Phase-correct direction turns at either end of the sequence.
    assign nextDown = atTop ? 1'b1 : (atBottom ? 1'b0 : countDown_q);

    always_comb
    begin
        unique case (waveMode_q)
            WM_CLEAR_ON_MATCH: countNext = atTop ? COUNT_BOTTOM : count_q + 8'h01;
            WM_PHASE_PWM:      countNext = nextDown ? count_q - 8'h01 : count_q + 8'h01;
            WM_NORMAL, WM_FAST_PWM: countNext = count_q + 8'h01;
        endcase
    end

    // Count register; a software write wins over a tick in the same cycle.
    // reset clears state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_q     <= RESET_BYTE;
            countDown_q <= 1'b0;
        end
        else if (cpuCountWr)
        begin
            count_q <= wData_q[7:0];
        end
        else if (tick)
        begin
            count_q     <= countNext;
            countDown_q <= (waveMode_q == WM_PHASE_PWM) ? nextDown : 1'b0;
        end
    end

    // ****************************************************************
    // Compare registers
    // ****************************************************************
    // Fast PWM reloads as the count wraps to bottom, phase-correct at top.
    assign reloadPoint = tick && (((waveMode_q == WM_FAST_PWM) && (count_q == COUNT_MAX)) ||
                                  ((waveMode_q == WM_PHASE_PWM) && atTop));

    // Buffered compare in PWM modes, direct in the others.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            compareActive_q <= RESET_BYTE;
            compareBuffer_q <= RESET_BYTE;
        end
        else
        begin
            if (cpuCompareWr)
            begin
                compareBuffer_q <= wData_q[7:0];
            end
            if (cpuCompareWr && !isPwm)
            begin
                compareActive_q <= wData_q[7:0];
            end
            else if (isPwm && reloadPoint)
            begin
                compareActive_q <= compareBuffer_q;
            end
        end
    end

    // ****************************************************************
    // Match blocking, flags and output state
    // ****************************************************************
    // block next tick after count write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blockMatch_q <= 1'b0;
        end
        else if (cpuCountWr)
        begin
            blockMatch_q <= 1'b1;
        end
        else if (tick)
        begin
            blockMatch_q <= 1'b0;
        end
    end

    assign matchEvent = tick && match && !blockMatch_q && !cpuCountWr;

    // Sticky flags; a set in the cycle of a clear wins so no event is lost.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            overflowFlag_q <= 1'b0;
            matchFlag_q    <= 1'b0;
        end
        else
        begin
            if (wrapPoint || (tick && (waveMode_q == WM_PHASE_PWM) && atBottom && !cpuCountWr))
            begin
                overflowFlag_q <= 1'b1;
            end
            else if (overflowIrqAck || (cpuStatusWr && wData_q[STAT_OVF_BIT]))
            begin
                overflowFlag_q <= 1'b0;
            end
            if (matchEvent)
            begin
                matchFlag_q <= 1'b1;
            end
            else if (compareIrqAck || (cpuStatusWr && wData_q[STAT_MATCH_BIT]))
            begin
                matchFlag_q <= 1'b0;
            end
        end
    end

    // Level on match in PWM modes; inverting mode and down counting swap it.
    assign pwmLevel = outMode_q[0] ^ ((waveMode_q == WM_PHASE_PWM) && countDown_q);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            outState_q <= 1'b0;
        end
        else if ((matchEvent || forceStrobe) && !isPwm)
        begin
            outState_q <= non_pwm_action(outMode_q, outState_q);
        end
        else if (matchEvent && outMode_q[1])
        begin
            outState_q <= pwmLevel;
        end
        else if (tick && (waveMode_q == WM_FAST_PWM) && (count_q == COUNT_MAX) && outMode_q[1])
        begin
            outState_q <= ~outMode_q[0];
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // indications to waveform logic
    assign matchOut           = match;
    assign topOut             = atTop;
    assign bottomOut          = atBottom;
    assign countDownOut       = countDown_q;
    assign compareOutputMode  = outMode_q;
    assign compareOutputState = outState_q;
    assign compareIrq         = matchFlag_q & irqEnable_q[STAT_MATCH_BIT];
    assign overflowIrq        = overflowFlag_q & irqEnable_q[STAT_OVF_BIT];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_stopped_holds: assert property ((clockSelect_q == 3'h0) && !cpuCountWr |=> $stable(count_q))
        else $error("count moved while stopped");
    chk_write_wins: assert property (cpuCountWr |=> count_q == $past(wData_q[7:0]))
        else $error("count write lost");
    chk_one_step: assert property (tick && !cpuCountWr && !atTop && !atBottom
        |=> (count_q == $past(count_q) + 8'h01) || (count_q == $past(count_q) - 8'h01))
        else $error("count step not one");
    chk_ctc_clear: assert property (tick && !cpuCountWr && (waveMode_q == WM_CLEAR_ON_MATCH) && atTop
        |=> count_q == COUNT_BOTTOM)
        else $error("clear-on-match did not clear");
    chk_match_flag: assert property (matchEvent |=> matchFlag_q)
        else $error("match flag not set");
    chk_blocked_match: assert property (cpuCountWr ##1 tick |-> !matchEvent)
        else $error("match not blocked after count write");
    chk_irq_request: assert property (compareIrqAck && !matchEvent |=> !compareIrq)
        else $error("compare irq not cleared by service");
    chk_flag_w1c: assert property (cpuStatusWr && !wData_q[STAT_MATCH_BIT] && matchFlag_q && !compareIrqAck
        |=> matchFlag_q)
        else $error("writing zero cleared flag");
    chk_buffer_hold: assert property (isPwm && !reloadPoint && !$past(isPwm, 1) == 1'b0
        && $stable(waveMode_q) |=> $stable(compareActive_q))
        else $error("active compare changed off top/bottom");
    chk_force_noflag: assert property (forceStrobe && !matchEvent && !matchFlag_q |=> !matchFlag_q)
        else $error("force set the match flag");
    chk_ovf_wrap: assert property (wrapPoint |=> overflowFlag_q)
        else $error("overflow not set at wrap");

    cov_ctc_wrap:   cover property (tick && (waveMode_q == WM_CLEAR_ON_MATCH) && atTop);
    cov_pwm_reload: cover property (isPwm && reloadPoint);
    cov_block:      cover property (blockMatch_q && tick && match);
    cov_force:      cover property (forceStrobe && !isPwm);

endmodule // tmc_timer

// ==== common/tmc_pkg.sv ====
// ****************************************************************
// Timer counter package
// ****************************************************************
package tmc_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_COUNT   = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_IRQEN   = 8'h10;
    localparam logic [7:0] OFS_STATE   = 8'h14;

    // Field positions in the control register.
    localparam int CTRL_CS_LSB    = 0;
    localparam int CTRL_WM_LSB    = 3;
    localparam int CTRL_OM_LSB    = 5;
    localparam int CTRL_FORCE_BIT = 7;

    // Field positions in the status and enable registers.
    localparam int STAT_OVF_BIT   = 0;
    localparam int STAT_MATCH_BIT = 1;

    // Field position of the output state in the state register.
    localparam int STATE_OUT_BIT  = 8;

    // Count limits and reset values.
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] RESET_BYTE   = 8'h00;

    // Prescaler width; the slowest tick divides the clock by 1024.
    localparam int PRESCALE_W = 10;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Counting sequences selected by the waveform mode bits.
    typedef enum logic [1:0]
    {
        WM_NORMAL,
        WM_PHASE_PWM,
        WM_CLEAR_ON_MATCH,
        WM_FAST_PWM
    } tmc_wave_mode_t;

endpackage : tmc_pkg

// ==== test/tmc_irq_host.sv ====
`timescale 1ns/1ns
// ****************************************
// Interrupt servicing side of the CPU
// ****************************************
module tmc_irq_host
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic irq,
    output      logic ack
);
    logic [2:0] wait_q;

    // Entry into a handler takes a few cycles, so the ack is late, not instant.
    // service clears flag
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_q <= 3'h0;
            ack    <= 1'b0;
        end
        else
        begin
            wait_q <= (enable && irq && !ack) ? wait_q + 3'h1 : 3'h0;
            ack    <= (wait_q == 3'h3);
        end
    end
endmodule // tmc_irq_host

// ==== test/tmc_timer_bench.sv ====
`timescale 1ns/1ns
// ****************************************
// Timer counter bench
// ****************************************
module tmc_timer_bench;
    import tmc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tmc_row_t;
    logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, ovfAck, hostEn;
    logic        awready, wready, bvalid, arready, rvalid, ovfIrq, cmpIrq, cmpAck;
    logic        matchOut, topOut, bottomOut, countDown, outState;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs, omode;
    int          numErrors, nTests;
    tmc_row_t    rows [4];

    tmc_timer tmc_timer_inst (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .overflowIrqAck(ovfAck), .compareIrqAck(cmpAck),
        .overflowIrq(ovfIrq), .compareIrq(cmpIrq), .matchOut(matchOut), .topOut(topOut),
        .bottomOut(bottomOut), .countDownOut(countDown), .compareOutputMode(omode),
        .compareOutputState(outState));
    tmc_irq_host tmc_irq_host_inst (.clk(clk), .rstn(rstn), .enable(hostEn), .irq(cmpIrq), .ack(cmpAck));

    // Free running clock at 100 MHz.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Handshakes are judged at the falling edge so the design's own edge updates never race us.
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = awready; tw = wready; tb = bvalid; r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        while (!tb);
        bready <= 1'b0;
    endtask

    task automatic rdReg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = arready; tr = rvalid; d = rdata; r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        while (!tr);
        rready <= 1'b0;
    endtask

    task automatic summarize;
        $display("errors %0d checks %0d", numErrors, nTests);
        if (numErrors == 0 && nTests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Cut a hang short well after the tests should have ended.
    initial
    begin
        repeat (20000) @(posedge clk);
        numErrors++;
        summarize();
    end

    // Main sequence; software writes the count with the compare value to test blocking and the clear-on-match bound.
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, ovfAck, hostEn} = '0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF; rstn = 1'b0;
        rows = '{'{OFS_COUNT, 32'h5A, 32'h5A}, '{OFS_CTRL, 32'h60, 32'h60},
                 '{OFS_IRQEN, 32'h3, 32'h3}, '{OFS_COMPARE, 32'h5A, 32'h5A}};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rdReg(OFS_STATUS, rd, rs); chk("status reset", rd, 32'h0);
        rdReg(OFS_STATE, rd, rs); chk("state reset", rd, 32'h0);
        foreach (rows[i])
        begin
            wrReg(rows[i].a, rows[i].d, rs);
            rdReg(rows[i].a, rd, rs); chk("table", rd, rows[i].e);
        end
        chk("match", matchOut, 1'b1);
        chk("mode", omode, 2'h3);
        repeat (20) @(posedge clk);
        rdReg(OFS_COUNT, rd, rs); chk("stopped", rd, 32'h5A);
        wrReg(8'h1C, 32'h1, rs); chk("wr resp", rs, RESP_SLVERR);
        rdReg(8'h1C, rd, rs); chk("rd resp", rs, RESP_SLVERR);
        // Software sets the output state with a forced compare before using the pin.
        wrReg(OFS_CTRL, 32'hA0, rs); chk("forced", outState, 1'b1);
        rdReg(OFS_STATUS, rd, rs); chk("force flag", rd, 32'h0);
        wrReg(OFS_CTRL, 32'h38, rs); chk("kept", outState, 1'b1);
        wrReg(OFS_COMPARE, 32'h33, rs);
        rdReg(OFS_STATE, rd, rs); chk("active", rd[7:0], 8'h5A);
        rdReg(OFS_COMPARE, rd, rs); chk("buffer", rd, 32'h33);
        wrReg(OFS_COUNT, 32'hFF, rs); chk("top", topOut, 1'b1);
        wrReg(OFS_CTRL, 32'h39, rs);
        rdReg(OFS_STATE, rd, rs); chk("reload", rd[7:0], 8'h33);
        wrReg(OFS_CTRL, 32'h0, rs);
        wrReg(OFS_STATUS, 32'h3, rs);
        wrReg(OFS_COMPARE, 32'h10, rs);
        wrReg(OFS_COUNT, 32'h10, rs);
        wrReg(OFS_CTRL, 32'h1, rs);
        rdReg(OFS_STATUS, rd, rs); chk("blocked", rd, 32'h0);
        repeat (300) @(posedge clk);
        chk("ovf irq", ovfIrq, 1'b1);
        chk("cmp irq", cmpIrq, 1'b1);
        wrReg(OFS_CTRL, 32'h0, rs);
        rdReg(OFS_STATUS, rd, rs); chk("flags", rd, 32'h3);
        wrReg(OFS_STATUS, 32'h0, rs);
        rdReg(OFS_STATUS, rd, rs); chk("w0", rd, 32'h3);
        wrReg(OFS_STATUS, 32'h1, rs);
        rdReg(OFS_STATUS, rd, rs); chk("w1", rd, 32'h2);
        hostEn <= 1'b1;
        repeat (10) @(posedge clk);
        rdReg(OFS_STATUS, rd, rs); chk("serviced", rd, 32'h0);
        wrReg(OFS_COUNT, 32'h0, rs); chk("bottom", bottomOut, 1'b1);
        // Clear-on-match: a count write of the compare value while running must not escape the bound.
        wrReg(OFS_COMPARE, 32'h8, rs);
        wrReg(OFS_CTRL, 32'h11, rs);
        wrReg(OFS_COUNT, 32'h8, rs);
        repeat (20) @(posedge clk);
        wrReg(OFS_CTRL, 32'h0, rs);
        rdReg(OFS_COUNT, rd, rs); chk("ctc bound", rd <= 32'h8, 1'b1);
        // Phase-correct mode turns downward once the count reaches the top.
        wrReg(OFS_COUNT, 32'hF0, rs);
        wrReg(OFS_CTRL, 32'h09, rs);
        repeat (30) @(posedge clk);
        chk("down", countDown, 1'b1);
        wrReg(OFS_CTRL, 32'h0, rs);
        // A write without lane zero is ignored but still answered OKAY.
        wrReg(OFS_COUNT, 32'h44, rs);
        wstrb <= 4'hE;
        wrReg(OFS_COUNT, 32'h77, rs); chk("strobe resp", rs, RESP_OKAY);
        wstrb <= 4'hF;
        rdReg(OFS_COUNT, rd, rs); chk("strobe", rd, 32'h44);
        // Reset again in mid-run; the count and state registers must return to zero.
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdReg(OFS_COUNT, rd, rs); chk("count rerst", rd, 32'h0);
        rdReg(OFS_STATE, rd, rs); chk("state rerst", rd, 32'h0);
        chk("bottom rerst", bottomOut, 1'b1);
        summarize();
    end
endmodule // tmc_timer_bench
